// ### src/its_pkg.sv
package its_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_HOLD,
        ST_DATA,
        ST_DACK
    } its_state_e;

    // Status/control register, bit 7 down to bit 0
    typedef struct packed {
        logic byte_done_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic transmit_direction_select;
        logic ack_to_send_bit;
        logic master_read_request_flag;
        logic wake_enable;
        logic ack_received_flag;
    } its_stat_s;

endpackage

// ### src/its_regs.svh
// What this block does
// - Shift in seven address bits, compare own
// - Address match sets flag, raises interrupt
// - Eighth bit stored as read-request flag
// - Matched address gets low ack, ninth slot
// - START is SDA fall, SCL high; busy
// - One interrupt: match, byte, time-out
// - Hold SCL low until data access
// - Bytes are eight bits, MSB first
// - Receiving: drive ack-to-send bit on ninth
// - Transmit nack releases SDA for STOP
// - Transmitting: record master ack bit
// - Slave never drives a START
// - Direction bit selects transmit or receive
// - Timer starts on match, restarts, stops
// - Time-out when count passes period
// - Time-out halts, clears enable, sets flag
// - Time-out resets status register and byte engine
// - Period is select plus one times 32
// - Time-out flag cleared only by zero write
// - Byte-done low while moving, set at end
// - STOP clears bus-busy flag
// - Glitch filter two or four clocks
`ifndef ITS_REGS_SVH
`define ITS_REGS_SVH

// ==========================================
// Register offsets
`define ITS_OFS_MODE    3'h0
`define ITS_OFS_STAT    3'h1
`define ITS_OFS_ADDR    3'h2
`define ITS_OFS_DATA    3'h3
`define ITS_OFS_TOC     3'h4

// ==========================================
// Reset values and fields
`define ITS_MODE_POR    8'he0
`define ITS_STAT_POR    8'h81
`define ITS_TOC_POR     8'h00
`define ITS_MODE_I2C    3'h6
`define ITS_TOC_EN_BIT  7
`define ITS_TOC_FLG_BIT 6

// ==========================================
// Timing counts
`define ITS_FLT_SHORT   3'h2
`define ITS_FLT_LONG    3'h4
`define ITS_PRE_LAST    5'h1f

`endif

// ### src/its_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"

module its_slave
    import its_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Register port
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // Slow sub-clock for the time-out
    input  wire logic       SUB_CLK,
    // Bus lines, open drain
    input  wire logic       SCL_I,
    output logic            SCL_O,
    output logic            SCL_OE_N,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_N,
    // Module interrupt request
    output logic            IRQ
);

    // ==========================================
    // Registers
    logic [7:0] mode_q;
    logic [7:0] own_q;
    logic [7:0] data_q;
    logic [7:0] toc_q;
    its_stat_s  stat_q;
    its_state_e state_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic [7:0] rdata_q;
    logic       irq_q;
    logic       scl_oe_n_q;
    logic       sda_oe_n_q;
    logic       line_o_q;

    logic       active;
    logic       wr_data;
    logic       rd_data;
    logic       wr_stat;
    logic       wr_toc;
    logic       is_tx;

    assign active  = mode_q[1] && !mode_q[4] &&
                     (mode_q[7:5] == `ITS_MODE_I2C);
    assign wr_data = WR && (ADDR == `ITS_OFS_DATA);
    assign rd_data = RD && (ADDR == `ITS_OFS_DATA);
    assign wr_stat = WR && (ADDR == `ITS_OFS_STAT);
    assign wr_toc  = WR && (ADDR == `ITS_OFS_TOC);
    assign is_tx   = stat_q.transmit_direction_select;

    // ==========================================
    // Pin synchronisers and glitch filters
    // Index 0 is SCL, index 1 is SDA
    logic [1:0] pin_raw;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] flt_q;
    logic [1:0] prev_q;
    logic [2:0] fcnt_q [2];
    logic [2:0] flt_len;

    assign pin_raw = {SDA_I, SCL_I};
    // Code 00 is undefined; the short filter is the safer guess
    assign flt_len = (mode_q[3:2] == 2'h1 || mode_q[3:2] == 2'h0) ?
                     `ITS_FLT_SHORT : `ITS_FLT_LONG;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pin
            always_ff @(posedge CLK) begin
                if (RST) begin
                    s1_q[g]   <= 1'b1;
                    s2_q[g]   <= 1'b1;
                    flt_q[g]  <= 1'b1;
                    prev_q[g] <= 1'b1;
                    fcnt_q[g] <= 3'h0;
                end else begin
                    s1_q[g]   <= pin_raw[g];
                    s2_q[g]   <= s1_q[g];
                    prev_q[g] <= flt_q[g];
                    if (s2_q[g] == flt_q[g]) begin
                        fcnt_q[g] <= 3'h0;
                    end else if (fcnt_q[g] + 3'h1 >= flt_len) begin
                        flt_q[g]  <= s2_q[g];
                        fcnt_q[g] <= 3'h0;
                    end else begin
                        fcnt_q[g] <= fcnt_q[g] + 3'h1;
                    end
                end
            end
        end
    endgenerate

    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic match_evt;
    logic done_evt;
    logic to_evt;
    logic sw_go;

    assign scl_rise  = active && flt_q[0] && !prev_q[0];
    assign scl_fall  = active && !flt_q[0] && prev_q[0];
    // SCL must be high before and after, so an edge on SCL
    // in the same cycle is never taken for a bus condition
    assign start_evt = active && flt_q[0] && prev_q[0] &&
                       !flt_q[1] && prev_q[1];
    assign stop_evt  = active && flt_q[0] && prev_q[0] &&
                       flt_q[1] && !prev_q[1];
    assign match_evt = (state_q == ST_ADDR) && scl_fall &&
                       (cnt_q == 4'h8) &&
                       (shift_q[7:1] == own_q[7:1]);
    assign done_evt  = (state_q == ST_DATA) && scl_fall &&
                       (cnt_q == (is_tx ? 4'h7 : 4'h8));
    assign sw_go     = (state_q == ST_HOLD) &&
                       ((wr_data && is_tx) ||
                        (rd_data && !is_tx));

    // ==========================================
    // Byte engine
    // The slave only ever pulls SDA inside a byte or ack slot, so
    // it can never form a START of its own
    always_ff @(posedge CLK) begin
        if (RST || to_evt || !active || stop_evt) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 4'h0;
            shift_q    <= 8'h00;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else if (start_evt) begin
            state_q    <= ST_ADDR;
            cnt_q      <= 4'h0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], flt_q[1]};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        if (match_evt) begin
                            sda_oe_n_q <= 1'b0;
                            state_q    <= ST_AACK;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        sda_oe_n_q <= 1'b1;
                        scl_oe_n_q <= 1'b0;
                        state_q    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (sw_go) begin
                        scl_oe_n_q <= 1'b1;
                        cnt_q      <= 4'h0;
                        state_q    <= ST_DATA;
                        if (is_tx) begin
                            shift_q    <= WDATA;
                            sda_oe_n_q <= WDATA[7];
                        end
                    end
                end
                ST_DATA: begin
                    if (is_tx) begin
                        if (scl_fall) begin
                            if (cnt_q == 4'h7) begin
                                sda_oe_n_q <= 1'b1;
                                state_q    <= ST_DACK;
                            end else begin
                                cnt_q      <= cnt_q + 4'h1;
                                shift_q    <= {shift_q[6:0], 1'b0};
                                sda_oe_n_q <= shift_q[6];
                            end
                        end
                    end else if (scl_rise) begin
                        shift_q <= {shift_q[6:0], flt_q[1]};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (done_evt) begin
                        sda_oe_n_q <= stat_q.ack_to_send_bit;
                        state_q    <= ST_DACK;
                    end
                end
                ST_DACK: begin
                    if (scl_fall) begin
                        sda_oe_n_q <= 1'b1;
                        if (is_tx && stat_q.ack_received_flag) begin
                            state_q <= ST_IDLE;
                        end else begin
                            scl_oe_n_q <= 1'b0;
                            state_q    <= ST_HOLD;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Status and control flags
    always_ff @(posedge CLK) begin
        if (RST || to_evt) begin
            stat_q <= `ITS_STAT_POR;
        end else begin
            if (wr_stat) begin
                stat_q.transmit_direction_select <= WDATA[4];
                stat_q.ack_to_send_bit           <= WDATA[3];
                stat_q.wake_enable               <= WDATA[1];
            end
            if (!active) begin
                stat_q.byte_done_flag           <= 1'b1;
                stat_q.address_match_flag       <= 1'b0;
                stat_q.bus_busy_flag            <= 1'b0;
                stat_q.master_read_request_flag <= 1'b0;
                stat_q.ack_received_flag        <= 1'b1;
            end else begin
                if (wr_data || rd_data) begin
                    stat_q.byte_done_flag <= 1'b0;
                end
                if (start_evt) begin
                    stat_q.bus_busy_flag      <= 1'b1;
                    stat_q.byte_done_flag     <= 1'b0;
                    stat_q.address_match_flag <= 1'b0;
                end
                if (stop_evt) begin
                    stat_q.bus_busy_flag  <= 1'b0;
                    stat_q.byte_done_flag <= 1'b1;
                end
                if (match_evt) begin
                    stat_q.address_match_flag       <= 1'b1;
                    stat_q.master_read_request_flag <= shift_q[0];
                end
                if (done_evt) begin
                    stat_q.byte_done_flag <= 1'b1;
                end
                if (state_q == ST_DACK && is_tx && scl_rise) begin
                    stat_q.ack_received_flag <= flt_q[1];
                end
            end
        end
    end

    // ==========================================
    // Time-out counter
    logic [1:0] sub_sync_q;
    logic       sub_prev_q;
    logic [4:0] pre_q;
    logic [5:0] tcnt_q;
    logic       run_q;
    logic       tick;

    assign tick   = sub_sync_q[1] && !sub_prev_q &&
                    (pre_q == `ITS_PRE_LAST);
    assign to_evt = run_q && tick && !scl_fall &&
                    (tcnt_q == toc_q[5:0]);

    always_ff @(posedge CLK) begin
        if (RST) begin
            sub_sync_q <= 2'h0;
            sub_prev_q <= 1'b0;
            pre_q      <= 5'h00;
        end else begin
            sub_sync_q <= {sub_sync_q[0], SUB_CLK};
            sub_prev_q <= sub_sync_q[1];
            if (sub_sync_q[1] && !sub_prev_q) begin
                pre_q <= pre_q + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || to_evt || stop_evt || !active) begin
            run_q  <= 1'b0;
            tcnt_q <= 6'h00;
        end else if (match_evt) begin
            run_q  <= toc_q[`ITS_TOC_EN_BIT];
            tcnt_q <= 6'h00;
        end else if (scl_fall) begin
            tcnt_q <= 6'h00;
        end else if (run_q && tick) begin
            tcnt_q <= tcnt_q + 6'h01;
        end
    end

    // ==========================================
    // Register file
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_q <= `ITS_MODE_POR;
            own_q  <= 8'h00;
        end else if (WR && ADDR == `ITS_OFS_MODE) begin
            mode_q <= {WDATA[7:1], 1'b0};
        end else if (WR && ADDR == `ITS_OFS_ADDR) begin
            own_q <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            data_q <= 8'h00;
        end else if (done_evt && !is_tx) begin
            // Eight rises have filled the shifter, MSB first
            data_q <= shift_q;
        end else if (wr_data) begin
            data_q <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            toc_q <= `ITS_TOC_POR;
        end else begin
            if (wr_toc) begin
                toc_q[7] <= WDATA[7];
                toc_q[5:0] <= WDATA[5:0];
                if (!WDATA[`ITS_TOC_FLG_BIT]) begin
                    toc_q[`ITS_TOC_FLG_BIT] <= 1'b0;
                end
            end
            // Set wins over a clear in the same cycle
            if (to_evt) begin
                toc_q[`ITS_TOC_EN_BIT]  <= 1'b0;
                toc_q[`ITS_TOC_FLG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || !RD) begin
            rdata_q <= 8'h00;
        end else if (ADDR == `ITS_OFS_MODE) begin
            rdata_q <= mode_q;
        end else if (ADDR == `ITS_OFS_STAT) begin
            rdata_q <= stat_q;
        end else if (ADDR == `ITS_OFS_ADDR) begin
            rdata_q <= own_q;
        end else if (ADDR == `ITS_OFS_DATA) begin
            rdata_q <= data_q;
        end else if (ADDR == `ITS_OFS_TOC) begin
            rdata_q <= toc_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q    <= 1'b0;
            line_o_q <= 1'b0;
        end else begin
            irq_q    <= match_evt || done_evt || to_evt;
            line_o_q <= 1'b0;
        end
    end

    assign RDATA    = rdata_q;
    assign IRQ      = irq_q;
    assign SCL_O    = line_o_q;
    assign SDA_O    = line_o_q;
    assign SCL_OE_N = scl_oe_n_q;
    assign SDA_OE_N = sda_oe_n_q;

    // ==========================================
    // Assertions
    property p_start_busy;
        @(posedge CLK) disable iff (RST)
        start_evt && !to_evt |=> stat_q.bus_busy_flag &&
                                 !stat_q.byte_done_flag;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("START did not set busy");

    property p_stop_free;
        @(posedge CLK) disable iff (RST)
        stop_evt |=> !stat_q.bus_busy_flag && state_q == ST_IDLE;
    endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("STOP did not free the bus");

    property p_match;
        @(posedge CLK) disable iff (RST)
        match_evt && !to_evt |=> stat_q.address_match_flag && irq_q &&
            !SDA_OE_N && stat_q.master_read_request_flag ==
            $past(shift_q[0]);
    endproperty
    a_match: assert property (p_match)
        else $error("address match effects missing");

    property p_hold;
        @(posedge CLK) disable iff (RST)
        state_q == ST_HOLD && !sw_go && active && !stop_evt &&
        !start_evt && !to_evt |=> !SCL_OE_N;
    endproperty
    a_hold: assert property (p_hold)
        else $error("SCL released while waiting");

    property p_timeout;
        @(posedge CLK) disable iff (RST)
        to_evt |=> !toc_q[7] && toc_q[6] && irq_q && !run_q &&
                   stat_q == `ITS_STAT_POR && SCL_OE_N && SDA_OE_N;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out effects missing");

    property p_flag_sticky;
        @(posedge CLK) disable iff (RST)
        toc_q[6] && !(wr_toc && !WDATA[6]) |=> toc_q[6];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("time-out flag lost");

    property p_nack_release;
        @(posedge CLK) disable iff (RST)
        state_q == ST_DACK && is_tx && stat_q.ack_received_flag &&
        scl_fall && !to_evt |=> SDA_OE_N && state_q == ST_IDLE;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("SDA held after nack");

    property p_rx_ack;
        @(posedge CLK) disable iff (RST)
        done_evt && !is_tx && !to_evt && !stop_evt |=>
            SDA_OE_N == $past(stat_q.ack_to_send_bit) ##1
            stat_q.byte_done_flag || !active;
    endproperty
    a_rx_ack: assert property (p_rx_ack)
        else $error("ack-to-send not driven");

endmodule
`default_nettype wire

// ### verification/its_master.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Two-wire bus master, open-drain pulls
module its_master #(
    parameter int T_STEP = 400
) (
    // Line levels seen on the bus
    input  wire logic scl,
    input  wire logic sda,
    // Pulls, 1 = released to the pull-up
    output logic      scl_rel,
    output logic      sda_rel,
    // Stretch waits that ran out
    output int        hang_cnt
);
    initial begin
        scl_rel  = 1'b1;
        sda_rel  = 1'b1;
        hang_cnt = 0;
    end

    // ==========================================
    // Bit slot; changes stay 10 system clocks apart for the input filter
    task automatic xfer(input logic b, output logic s);
        int n;
        n = 0;
        #(T_STEP);
        sda_rel = b;
        #(T_STEP);
        scl_rel = 1'b1;
        while (scl !== 1'b1 && n < 100) begin
            #(T_STEP);
            n++;
        end
        if (n == 100) begin
            hang_cnt++;
            $display("Error at %0t: SCL stretch wait ran out", $time);
        end
        #(T_STEP);
        s = sda;
        scl_rel = 1'b0;
    endtask

    task automatic start();
        #(T_STEP);
        sda_rel = 1'b0;
        #(T_STEP);
        scl_rel = 1'b0;
    endtask

    task automatic stop();
        #(T_STEP);
        sda_rel = 1'b0;
        #(T_STEP);
        scl_rel = 1'b1;
        #(T_STEP);
        sda_rel = 1'b1;
        #(T_STEP);
    endtask

    // Returns the ninth-bit level seen on SDA
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            xfer(d[i], s);
        xfer(1'b1, ack);
        #(T_STEP);
    endtask

    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, s);
            d[i] = s;
        end
        xfer(ack, s);
        #(T_STEP);
    endtask
endmodule

`default_nettype wire

// ### verification/tb_i2c_slave_with_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"

// ==========================================
// Bench for the two-wire slave
module tb_i2c_slave_with_timeout;
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic       sub_clk   = 1'b0;
    logic [2:0] addr      = 3'h0;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic [7:0] rdata;
    logic       scl_o;
    logic       scl_oe_n;
    logic       sda_o;
    logic       sda_oe_n;
    logic       irq;
    logic       m_scl;
    logic       m_sda;
    int         hang;
    int         error_cnt = 0;
    int         checked   = 0;
    int         irq_n     = 0;
    logic [7:0] v;
    logic       ack;
    // Pull-ups: a line is low while any party pulls it
    wire        scl_w     = m_scl & (scl_oe_n | scl_o);
    wire        sda_w     = m_sda & (sda_oe_n | sda_o);

    always #20 clk = ~clk;
    always #100 sub_clk = ~sub_clk;
    // The request is a one-cycle pulse, so pulses are counted
    always @(posedge clk)
        if (irq === 1'b1)
            irq_n++;

    its_slave i_dut (
        .CLK      (clk),
        .RST      (rst),
        .ADDR     (addr),
        .WDATA    (wdata),
        .WR       (wr),
        .RD       (rd),
        .RDATA    (rdata),
        .SUB_CLK  (sub_clk),
        .SCL_I    (scl_w),
        .SCL_O    (scl_o),
        .SCL_OE_N (scl_oe_n),
        .SDA_I    (sda_w),
        .SDA_O    (sda_o),
        .SDA_OE_N (sda_oe_n),
        .IRQ      (irq)
    );

    its_master i_mst (
        .scl      (scl_w),
        .sda      (sda_w),
        .scl_rel  (m_scl),
        .sda_rel  (m_sda),
        .hang_cnt (hang)
    );

    // ==========================================
    // Shared tasks
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chkm(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        reg_rd(a, v);
        cmp8(v & m, e);
    endtask

    task automatic final_report();
        error_cnt += hang;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chkm(`ITS_OFS_MODE, 8'hff, `ITS_MODE_POR);
        chkm(`ITS_OFS_STAT, 8'hff, `ITS_STAT_POR);
        chkm(`ITS_OFS_ADDR, 8'hff, 8'h00);
        chkm(`ITS_OFS_DATA, 8'hff, 8'h00);
        chkm(`ITS_OFS_TOC, 8'hff, `ITS_TOC_POR);
        reg_wr(3'h7, 8'hff);
        chkm(3'h7, 8'hff, 8'h00);
        cmp8({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    endtask

    task automatic t_init();
        reg_wr(`ITS_OFS_MODE, 8'hc6);
        reg_wr(`ITS_OFS_ADDR, 8'ha0);
        chkm(`ITS_OFS_MODE, 8'hff, 8'hc6);
        chkm(`ITS_OFS_ADDR, 8'hff, 8'ha0);
    endtask

    // Filter codes 3 down to 1, ending on the short one
    task automatic t_deb();
        for (int d = 3; d >= 1; d--) begin
            reg_wr(`ITS_OFS_MODE, 8'hc2 | 8'(d << 2));
            i_mst.start();
            i_mst.send(8'ha0, ack);
            cmp8({7'h0, ack}, 8'h00);
            reg_rd(`ITS_OFS_DATA, v);
            i_mst.stop();
        end
    endtask

    // Differs from the own address in bit 1 only, its lowest address bit
    task automatic t_nomatch();
        int n0;
        n0 = irq_n;
        i_mst.start();
        i_mst.send(8'ha2, ack);
        cmp8({7'h0, ack}, 8'h01);
        chkm(`ITS_OFS_STAT, 8'h60, 8'h20);
        cmp8(8'(irq_n - n0), 8'h00);
        i_mst.stop();
        chkm(`ITS_OFS_STAT, 8'h20, 8'h00);
    endtask

    task automatic t_rx();
        int n0;
        n0 = irq_n;
        i_mst.start();
        i_mst.send(8'ha0, ack);
        cmp8({7'h0, ack}, 8'h00);
        chkm(`ITS_OFS_STAT, 8'h64, 8'h60);
        cmp8(8'(irq_n - n0), 8'h01);
        cmp8({7'h0, scl_oe_n}, 8'h00);
        reg_rd(`ITS_OFS_DATA, v);
        @(posedge clk);
        #1;
        cmp8({7'h0, scl_oe_n}, 8'h01);
        i_mst.send(8'h3c, ack);
        cmp8({7'h0, ack}, 8'h00);
        cmp8(8'(irq_n - n0), 8'h02);
        chkm(`ITS_OFS_STAT, 8'h80, 8'h80);
        chkm(`ITS_OFS_DATA, 8'hff, 8'h3c);
        chkm(`ITS_OFS_STAT, 8'h80, 8'h00);
        reg_wr(`ITS_OFS_STAT, 8'h08);
        i_mst.send(8'hc3, ack);
        cmp8({7'h0, ack}, 8'h01);
        chkm(`ITS_OFS_DATA, 8'hff, 8'hc3);
        i_mst.stop();
        chkm(`ITS_OFS_STAT, 8'ha0, 8'h80);
    endtask

    task automatic t_tx();
        reg_wr(`ITS_OFS_STAT, 8'h00);
        i_mst.start();
        i_mst.send(8'ha1, ack);
        cmp8({7'h0, ack}, 8'h00);
        chkm(`ITS_OFS_STAT, 8'h44, 8'h44);
        reg_wr(`ITS_OFS_STAT, 8'h10);
        reg_wr(`ITS_OFS_DATA, 8'h96);
        i_mst.recv(1'b0, v);
        cmp8(v, 8'h96);
        chkm(`ITS_OFS_STAT, 8'h01, 8'h00);
        reg_wr(`ITS_OFS_DATA, 8'h5a);
        i_mst.recv(1'b1, v);
        cmp8(v, 8'h5a);
        chkm(`ITS_OFS_STAT, 8'h01, 8'h01);
        cmp8({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
        i_mst.stop();
        reg_wr(`ITS_OFS_STAT, 8'h00);
    endtask

    // Select 3: four ticks of 32 sub-clocks, first one up to 31 short
    task automatic t_timeout();
        int n0;
        int n;
        n0 = irq_n;
        n  = 0;
        reg_wr(`ITS_OFS_TOC, 8'h83);
        i_mst.start();
        i_mst.send(8'ha0, ack);
        reg_rd(`ITS_OFS_DATA, v);
        i_mst.stop();
        repeat (700) @(posedge clk);
        cmp8(8'(irq_n - n0), 8'h01);
        chkm(`ITS_OFS_TOC, 8'hff, 8'h83);
        i_mst.start();
        i_mst.send(8'ha0, ack);
        while (irq_n == n0 + 2 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n == 1000) begin
            error_cnt++;
            $display("Error at %0t: no time-out seen", $time);
            final_report();
        end
        cmp8({7'h0, n inside {[474:660]}}, 8'h01);
        cmp8(8'(irq_n - n0), 8'h03);
        chkm(`ITS_OFS_TOC, 8'hff, 8'h43);
        chkm(`ITS_OFS_STAT, 8'hff, `ITS_STAT_POR);
        chkm(`ITS_OFS_ADDR, 8'hff, 8'ha0);
        chkm(`ITS_OFS_MODE, 8'hff, 8'hc6);
        cmp8({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
        reg_wr(`ITS_OFS_TOC, 8'h03);
        chkm(`ITS_OFS_TOC, 8'hff, 8'h03);
        i_mst.stop();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_init();
        t_deb();
        t_nomatch();
        t_rx();
        t_tx();
        t_timeout();
        final_report();
    end

    // Cuts the run short if anything hangs
    initial begin
        #3000000;
        error_cnt++;
        $display("Error at %0t: run limit reached", $time);
        final_report();
    end
endmodule

`default_nettype wire
